/* File: common/bkt_map.svh */
`ifndef BKT_MAP_SVH
`define BKT_MAP_SVH
// register indices; byte address is four times the index
`define BKT_IDX_CTL0   8'h20
`define BKT_IDX_CTL1   8'h21
`define BKT_IDX_AH     8'h22
`define BKT_IDX_AL     8'h23
`define BKT_IDX_DH     8'h24
`define BKT_IDX_DL     8'h25
`define BKT_IDX_STAT   8'h26
// control register 0 fields
`define BKT_C0_MODE_HI 7
`define BKT_C0_MODE_LO 6
`define BKT_C0_PROG    5
`define BKT_C0_RANGE1  1
`define BKT_C0_RANGE0  0
`define BKT_C0_MASK    8'hE3
// control register 1 fields
`define BKT_C1_DBE     6
`define BKT_C1_MBH     5
`define BKT_C1_MBL     4
`define BKT_C1_RW1E    3
`define BKT_C1_RW1     2
`define BKT_C1_RW0E    1
`define BKT_C1_RW0     0
`define BKT_C1_MASK    8'h7F
// status register fields
`define BKT_ST_TAGACT  0
`define BKT_ST_PEND    1
`define BKT_ST_HEAD    2
// reset values and tags
`define BKT_REG_RST    8'h00
`define BKT_TAG_NONE   3'h0
`define BKT_TAG_BOTH   2'h3
`define BKT_RESP_OKAY  2'h0
`define BKT_RESP_SLV   2'h2
`endif

/* File: common/bkt_pkg.sv */
package bkt_pkg;
  // breakpoint mode, in field encoding order 00..11
  typedef enum logic [1:0] {
    BKT_OFF,
    BKT_INT_DUAL,
    BKT_DBG_FULL,
    BKT_DBG_DUAL
  } bkt_mode_e;
  // queue entry: software interrupt flag, high tag, low tag
  typedef logic [2:0] bkt_tag_t;
  typedef logic [7:0] bkt_byte_t;
endpackage

/* File: common/bkt_cmp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface bkt_cmp_if;
  import bkt_pkg::*;
  logic [15:0] addr;
  logic [15:0] data;
  logic        rd;
  bkt_byte_t   ah;
  bkt_byte_t   al;
  bkt_byte_t   dh;
  bkt_byte_t   dl;
  bkt_byte_t   ctl0;
  bkt_byte_t   ctl1;
  logic        m0;
  logic        m1;
  modport top (output addr, data, rd, ah, al, dh, dl, ctl0, ctl1,
               input m0, m1);
  modport cmp (input addr, data, rd, ah, al, dh, dl, ctl0, ctl1,
               output m0, m1);
endinterface
`default_nettype wire

/* File: rtl/bkt_cmp.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bkt_map.svh"
module bkt_cmp (
  input wire logic clock,
  input wire logic nrst,
  bkt_cmp_if.cmp   cif
);
  import bkt_pkg::*;
  bkt_mode_e mode;
  logic      dual;
  logic      hi0, lo0, dir0, hi1, lo1, dir1, dhm, dlm;

  // address and direction compares for both breakpoints
  always_comb begin
    mode = bkt_mode_e'(cif.ctl0[`BKT_C0_MODE_HI:`BKT_C0_MODE_LO]);
    dual = (mode == BKT_INT_DUAL) || (mode == BKT_DBG_DUAL);
    hi0  = cif.addr[15:8] == cif.ah;
    lo0  = !cif.ctl0[`BKT_C0_RANGE0] || cif.addr[7:0] == cif.al;
    // direction: 0 writes, 1 reads; interrupt mode ignores it
    dir0 = !cif.ctl1[`BKT_C1_RW0E] || mode == BKT_INT_DUAL
           || cif.rd == cif.ctl1[`BKT_C1_RW0];
    dir1 = !cif.ctl1[`BKT_C1_RW1E] || mode != BKT_DBG_DUAL
           || cif.rd == cif.ctl1[`BKT_C1_RW1];
    hi1  = cif.addr[15:8] == cif.dh;
    lo1  = !cif.ctl0[`BKT_C0_RANGE1] || cif.addr[7:0] == cif.dl;
    dhm  = cif.ctl1[`BKT_C1_MBH] || cif.data[15:8] == cif.dh;
    dlm  = cif.ctl1[`BKT_C1_MBL] || cif.data[7:0] == cif.dl;
  end

  // a match needs every enabled byte and direction to agree
  always_comb begin
    cif.m0 = 1'b0;
    cif.m1 = 1'b0;
    unique case (mode)
      BKT_OFF: begin
        cif.m0 = 1'b0;
      end
      BKT_DBG_FULL: begin
        cif.m0 = hi0 && lo0 && dir0
                 && (!cif.ctl1[`BKT_C1_DBE] || (dhm && dlm));
      end
      BKT_INT_DUAL, BKT_DBG_DUAL: begin
        cif.m0 = hi0 && lo0 && dir0;
        cif.m1 = cif.ctl1[`BKT_C1_DBE] && hi1 && lo1 && dir1;
      end
    endcase
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (!nrst);
  off_quiet_a: assert property (mode == BKT_OFF |-> !cif.m0 && !cif.m1)
    else $error("match while breakpoints off");
  dir0_val_a: assert property (
    cif.m0 && mode != BKT_INT_DUAL && cif.ctl1[`BKT_C1_RW0E]
    |-> cif.rd == cif.ctl1[`BKT_C1_RW0])
    else $error("first breakpoint direction wrong");
  dir1_val_a: assert property (
    cif.m1 && mode == BKT_DBG_DUAL && cif.ctl1[`BKT_C1_RW1E]
    |-> cif.rd == cif.ctl1[`BKT_C1_RW1])
    else $error("second breakpoint direction wrong");
  addr_low_a: assert property (
    cif.m0 && cif.ctl0[`BKT_C0_RANGE0] |-> cif.addr == {cif.ah, cif.al})
    else $error("low address byte not compared");
  second_en_a: assert property (cif.m1 |-> dual
    && cif.ctl1[`BKT_C1_DBE] && cif.addr[15:8] == cif.dh)
    else $error("second breakpoint matched while disabled");
endmodule
`default_nettype wire

/* File: rtl/bkt_tagq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bkt_map.svh"
module bkt_tagq #(
  parameter int DEPTH = 4
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        flush,
  input  wire logic        push,
  input  wire bkt_pkg::bkt_tag_t push_tag,
  input  wire logic        pop,
  output bkt_pkg::bkt_tag_t head_tag
);
  import bkt_pkg::*;
  localparam int PW = $clog2(DEPTH);
  bkt_tag_t          mem [DEPTH];
  logic [PW-1:0]     rptr;
  logic [PW-1:0]     wptr;
  logic [PW:0]       count;
  logic              do_pop;
  logic              do_push;

  // tags advance with their program words
  assign do_pop  = pop && count != '0;
  assign do_push = push && (count != (PW+1)'(DEPTH) || do_pop);
  assign head_tag = count != '0 ? mem[rptr] : `BKT_TAG_NONE;

  // pointers and occupancy
  always_ff @(posedge clock) begin
    if (!nrst || flush) begin
      rptr  <= '0;
      wptr  <= '0;
      count <= '0;
    end else begin
      if (do_push)
        wptr <= wptr == PW'(DEPTH-1) ? '0 : wptr + 1'b1;
      if (do_pop)
        rptr <= rptr == PW'(DEPTH-1) ? '0 : rptr + 1'b1;
      count <= count + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

  // tag storage
  always_ff @(posedge clock) begin
    if (do_push)
      mem[wptr] <= push_tag;
  end
endmodule
`default_nettype wire

/* File: rtl/bkt_top.sv */
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "bkt_map.svh"
module bkt_top #(
  parameter int ADDR_W = 12,
  parameter int QDEPTH = 4
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              cpu_cyc,
  input  wire logic              cpu_fetch,
  input  wire logic [15:0]       cpu_addr,
  input  wire logic [15:0]       cpu_data,
  input  wire logic              cpu_rd,
  input  wire logic              instr_boundary,
  input  wire logic              queue_advance,
  input  wire logic              queue_flush,
  input  wire logic              bus_clock_fall,
  input  wire logic              background_debug_mode,
  input  wire logic              tagging_go_cmd,
  input  wire logic              core_strobe,
  input  wire logic              low_byte_strobe_in,
  output logic                   low_byte_strobe_out,
  output logic                   low_byte_strobe_oe,
  input  wire logic              debug_serial_pin_in,
  output logic                   debug_serial_oe,
  output logic                   serial_cmd_en,
  output logic                   break_to_debug,
  output logic                   software_interrupt
);
  import bkt_pkg::*;
  bkt_byte_t    ctl0, ctl1;
  bkt_byte_t    break_addr_high, break_addr_low;
  bkt_byte_t    break_data_high, break_data_low;
  logic         aw_held, w_held;
  logic [7:0]   aw_idx;
  bkt_byte_t    w_byte;
  logic         w_lane;
  logic         wr_go, wr_ok;
  bkt_byte_t    rd_byte;
  logic         rd_ok;
  logic         tagging_active;
  logic [1:0]   pin_tag;
  logic         pend;
  logic         hit;
  logic         prog_only;
  bkt_tag_t     push_tag;
  bkt_tag_t     head_tag;
  bkt_mode_e    mode;
  bkt_cmp_if    cif ();

  // register index of a byte address, or 8'hFF when an address bit above bit 9 is set
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:10] != '0)
      reg_index = 8'hFF;
    else
      reg_index = a[9:2];
  endfunction

  // which indices the slave answers
  function automatic logic mapped(input logic [7:0] idx);
    mapped = idx >= `BKT_IDX_CTL0 && idx <= `BKT_IDX_STAT;
  endfunction

  // write address channel: hold one address until the response
  always_ff @(posedge clock) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      aw_idx  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx  <= reg_index(s_axi_awaddr);
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  // write data channel: hold one data byte until the response
  always_ff @(posedge clock) begin
    if (!nrst) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = mapped(aw_idx);

  // channel readies and write response
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BKT_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `BKT_RESP_OKAY : `BKT_RESP_SLV;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control and breakpoint registers, byte lane 0 only
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctl0            <= `BKT_REG_RST;
      ctl1            <= `BKT_REG_RST;
      break_addr_high <= `BKT_REG_RST;
      break_addr_low  <= `BKT_REG_RST;
      break_data_high <= `BKT_REG_RST;
      break_data_low  <= `BKT_REG_RST;
    end else if (wr_go && w_lane) begin
      unique case (aw_idx)
        `BKT_IDX_CTL0: ctl0 <= w_byte & `BKT_C0_MASK;
        `BKT_IDX_CTL1: ctl1 <= w_byte & `BKT_C1_MASK;
        `BKT_IDX_AH:   break_addr_high <= w_byte;
        `BKT_IDX_AL:   break_addr_low  <= w_byte;
        `BKT_IDX_DH:   break_data_high <= w_byte;
        `BKT_IDX_DL:   break_data_low  <= w_byte;
        default:       ;
      endcase
    end
  end

  // read mux
  always_comb begin
    rd_ok   = mapped(reg_index(s_axi_araddr));
    rd_byte = 8'h00;
    unique case (reg_index(s_axi_araddr))
      `BKT_IDX_CTL0: rd_byte = ctl0;
      `BKT_IDX_CTL1: rd_byte = ctl1;
      `BKT_IDX_AH:   rd_byte = break_addr_high;
      `BKT_IDX_AL:   rd_byte = break_addr_low;
      `BKT_IDX_DH:   rd_byte = break_data_high;
      `BKT_IDX_DL:   rd_byte = break_data_low;
      `BKT_IDX_STAT: begin
        rd_byte[`BKT_ST_TAGACT] = tagging_active;
        rd_byte[`BKT_ST_PEND]   = pend;
        rd_byte[`BKT_ST_HEAD]   = head_tag != `BKT_TAG_NONE;
      end
      default:       rd_byte = 8'h00;
    endcase
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `BKT_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_ok ? `BKT_RESP_OKAY : `BKT_RESP_SLV;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // comparator hookup
  assign cif.addr = cpu_addr;
  assign cif.data = cpu_data;
  assign cif.rd   = cpu_rd;
  assign cif.ah   = break_addr_high;
  assign cif.al   = break_addr_low;
  assign cif.dh   = break_data_high;
  assign cif.dl   = break_data_low;
  assign cif.ctl0 = ctl0;
  assign cif.ctl1 = ctl1;

  bkt_cmp u_cmp (
    .clock (clock),
    .nrst  (nrst),
    .cif   (cif)
  );

  // interrupt mode always breaks on executed program bytes only
  assign mode = bkt_mode_e'(ctl0[`BKT_C0_MODE_HI:`BKT_C0_MODE_LO]);
  assign prog_only = ctl0[`BKT_C0_PROG] || mode == BKT_INT_DUAL;
  assign hit = cpu_cyc && !background_debug_mode && (cif.m0 || cif.m1);

  // tagging state, ended by entry into background debug
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tagging_active <= 1'b0;
      serial_cmd_en  <= 1'b1;
    end else if (background_debug_mode) begin
      tagging_active <= 1'b0;
      serial_cmd_en  <= 1'b1;
    end else if (tagging_go_cmd) begin
      tagging_active <= 1'b1;
      serial_cmd_en  <= 1'b0;
    end
  end

  // shared pins give way to the tag inputs
  always_ff @(posedge clock) begin
    if (!nrst) begin
      low_byte_strobe_out <= 1'b0;
      low_byte_strobe_oe  <= 1'b0;
      debug_serial_oe     <= 1'b0;
    end else begin
      low_byte_strobe_out <= core_strobe;
      low_byte_strobe_oe  <= !(tagging_active || tagging_go_cmd);
      debug_serial_oe     <= 1'b0;
    end
  end

  // tag pins latched on the falling bus clock, active low
  always_ff @(posedge clock) begin
    if (!nrst || !tagging_active)
      pin_tag <= 2'b00;
    else if (bus_clock_fall)
      pin_tag <= ~{debug_serial_pin_in, low_byte_strobe_in};
  end

  // fetched words carry pin tags, or a breakpoint tag
  always_comb begin
    push_tag = {1'b0, pin_tag};
    if (hit && prog_only && cpu_fetch)
      push_tag = {mode == BKT_INT_DUAL, `BKT_TAG_BOTH};
  end

  bkt_tagq #(
    .DEPTH (QDEPTH)
  ) u_tagq (
    .clock    (clock),
    .nrst     (nrst),
    .flush    (queue_flush),
    .push     (cpu_cyc && cpu_fetch),
    .push_tag (push_tag),
    .pop      (queue_advance),
    .head_tag (head_tag)
  );

  // non-program breaks wait for the next instruction boundary
  always_ff @(posedge clock) begin
    if (!nrst)
      pend <= 1'b0;
    else if (hit && !prog_only)
      pend <= 1'b1;
    else if (instr_boundary || background_debug_mode)
      pend <= 1'b0;
  end

  // break requests toward the core
  always_ff @(posedge clock) begin
    if (!nrst) begin
      break_to_debug     <= 1'b0;
      software_interrupt <= 1'b0;
    end else begin
      break_to_debug <= !background_debug_mode
        && ((pend && instr_boundary)
        || (queue_advance && head_tag[1:0] != 2'b00 && !head_tag[2]));
      software_interrupt <= !background_debug_mode
        && queue_advance && head_tag[2];
    end
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (!nrst);
  tag_stop_a: assert property (background_debug_mode |=> !tagging_active)
    else $error("tagging still active in debug");
  serial_gate_a: assert property (tagging_active |-> !serial_cmd_en)
    else $error("serial commands accepted while tagging");
  tag_go_a: assert property (
    tagging_go_cmd && !background_debug_mode
    |=> tagging_active ##1 !low_byte_strobe_oe)
    else $error("tagging go did not take the pins");
  tag_sample_a: assert property (bus_clock_fall && tagging_active |=>
    pin_tag == ~{$past(debug_serial_pin_in), $past(low_byte_strobe_in)})
    else $error("tag pins not latched at falling edge");
  head_enter_a: assert property (queue_advance && !background_debug_mode
    && head_tag[1:0] != 2'b00 && !head_tag[2] |=> break_to_debug)
    else $error("tagged head did not enter debug");
  pend_break_a: assert property (pend && instr_boundary && !hit
    && !background_debug_mode |=> break_to_debug && !pend)
    else $error("boundary break missed");
  reg_clear_a: assert property (disable iff (1'b0) !nrst |=> {break_addr_high,
    break_addr_low, break_data_high, break_data_low} == 32'h0000_0000)
    else $error("breakpoint registers not cleared");
  sint_cov: cover property (software_interrupt);
  dbg_cov: cover property (pend ##[1:20] break_to_debug);
  tag_cov: cover property (tagging_active && pin_tag == 2'b11);
  rd_cov: cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

/* File: testbench/bkt_tag_pod.sv */
`timescale 1ns/1ps
`default_nettype none
// debug pod: drives the two tag pins; a released pin sits at its pull-up
module bkt_tag_pod (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       drive,
  input  wire logic [1:0] level,
  output logic            tag_high_pin,
  output logic            tag_low_pin
);
  // levels move just after a rising edge and then hold, so every
  // falling bus clock edge in between sees a settled value
  always_ff @(posedge clock) begin
    if (!nrst || !drive) begin
      {tag_high_pin, tag_low_pin} <= 2'h3;
    end else begin
      {tag_high_pin, tag_low_pin} <= level;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/bkt_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bkt_map.svh"
module bkt_tb_top;
  import bkt_pkg::*;
  logic        clock, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb, fl;
  logic [1:0]  bresp, rresp, r, pod_lvl;
  logic        cyc_v, fetch, rd, bnd, adv, flush, fall, dbg, go, strobe;
  logic        lo_pin, so_out, so_oe, hi_pin, pod_lo, dso, scmd, brk, sint;
  logic        pod_on;
  logic [15:0] addr, data, a, d;
  logic [7:0]  c0, c1;
  int          failures, num_checks;
  // ctl0, ctl1, address, data, {rd, fetch, expect debug, expect swi}
  localparam logic [51:0] TBL [24] = '{
    {8'h81, 8'h40, 16'h1234, 16'h5678, 4'hA},
    {8'h81, 8'h40, 16'h1235, 16'h5678, 4'h8},
    {8'h81, 8'h40, 16'h1234, 16'h5679, 4'h8},
    {8'h81, 8'h60, 16'h1234, 16'hFF78, 4'hA},
    {8'h81, 8'h50, 16'h1234, 16'h56FF, 4'hA},
    {8'h80, 8'h40, 16'h12FF, 16'h5678, 4'hA},
    {8'h81, 8'h00, 16'h1234, 16'h0000, 4'hA},
    {8'h81, 8'h43, 16'h1234, 16'h5678, 4'h0},
    {8'h81, 8'h43, 16'h1234, 16'h5678, 4'hA},
    {8'h81, 8'h42, 16'h1234, 16'h5678, 4'h2},
    {8'h81, 8'h4C, 16'h1234, 16'h5678, 4'h2},
    {8'hC0, 8'h00, 16'h12AA, 16'h0000, 4'hA},
    {8'hC0, 8'h00, 16'h56AA, 16'h0000, 4'h8},
    {8'hC0, 8'h40, 16'h56AA, 16'h0000, 4'hA},
    {8'hC2, 8'h40, 16'h56AA, 16'h0000, 4'h8},
    {8'hC2, 8'h40, 16'h5678, 16'h0000, 4'hA},
    {8'hC0, 8'h4C, 16'h5600, 16'h0000, 4'h0},
    {8'hC0, 8'h4C, 16'h5600, 16'h0000, 4'hA},
    {8'hC0, 8'h48, 16'h5600, 16'h0000, 4'h2},
    {8'h01, 8'h40, 16'h1234, 16'h5678, 4'h8},
    {8'h40, 8'h00, 16'h1200, 16'h0000, 4'hD},
    {8'h40, 8'h00, 16'h1200, 16'h0000, 4'h8},
    {8'hA0, 8'h00, 16'h1200, 16'h0000, 4'hE},
    {8'hA0, 8'h00, 16'h1200, 16'h0000, 4'h8}
  };

  // shared low strobe pin: device or pod, pull-up when neither drives
  assign lo_pin = so_oe ? so_out : pod_lo;

  bkt_tag_pod pod (.clock(clock), .nrst(nrst), .drive(pod_on),
    .level(pod_lvl), .tag_high_pin(hi_pin), .tag_low_pin(pod_lo));

  bkt_top #(.ADDR_W(12), .QDEPTH(4)) dut (
    .clock(clock), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cpu_cyc(cyc_v), .cpu_fetch(fetch), .cpu_addr(addr),
    .cpu_data(data), .cpu_rd(rd), .instr_boundary(bnd),
    .queue_advance(adv), .queue_flush(flush), .bus_clock_fall(fall),
    .background_debug_mode(dbg), .tagging_go_cmd(go),
    .core_strobe(strobe), .low_byte_strobe_in(lo_pin),
    .low_byte_strobe_out(so_out), .low_byte_strobe_oe(so_oe),
    .debug_serial_pin_in(hi_pin), .debug_serial_oe(dso),
    .serial_cmd_en(scmd), .break_to_debug(brk),
    .software_interrupt(sint));

  // clock at 125 MHz
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic wr(input logic [7:0] idx, dv, output logic [1:0] rs);
    @(posedge clock);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, dv};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'h0;
  endtask

  task automatic rdr(input logic [7:0] idx, output logic [31:0] dv,
                     output logic [1:0] rs);
    @(posedge clock);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    dv = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask

  // one-cycle pulse on a control input chosen by k
  task automatic pls(input int k);
    @(posedge clock);
    case (k)
      0: bnd <= 1'h1;
      1: adv <= 1'h1;
      2: flush <= 1'h1;
      3: go <= 1'h1;
      default: fall <= 1'h1;
    endcase
    @(posedge clock);
    {bnd, adv, flush, go, fall} <= 5'h00;
  endtask

  task automatic cyc(input logic [15:0] ca, cd, input logic crd, cf);
    @(posedge clock);
    {cyc_v, addr, data, rd, fetch} <= {1'h1, ca, cd, crd, cf};
    @(posedge clock);
    {cyc_v, fetch} <= 2'h0;
  endtask

  // watch both break outputs over three cycles
  task automatic see(input logic [1:0] ex, input string m);
    logic [1:0] got;
    got = 2'h0;
    repeat (3) begin
      @(posedge clock);
      got = got | {brk, sint};
    end
    chk({30'h0, got}, {30'h0, ex}, m);
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out;
  end

  // main sequence
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {cyc_v, fetch, rd, bnd, adv, flush, fall, dbg, go} = 9'h000;
    {awaddr, araddr, wdata, addr, data} = 88'h0;
    {wstrb, strobe, pod_on, pod_lvl} = 8'hF3;
    repeat (2) @(posedge clock);
    nrst <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      rdr(8'(`BKT_IDX_AH + i), v, r);
      chk(v, 32'h0, "register reset value");
      wr(8'(`BKT_IDX_AH + i), 8'(8'hA5 ^ i), r);
      chk({30'h0, r}, {30'h0, `BKT_RESP_OKAY}, "write response");
      rdr(8'(`BKT_IDX_AH + i), v, r);
      chk(v, {24'h0, 8'(8'hA5 ^ i)}, "register readback");
    end
    wr(8'h3F, 8'h01, r);
    chk({30'h0, r}, {30'h0, `BKT_RESP_SLV}, "unmapped write response");
    rdr(8'h3F, v, r);
    chk({30'h0, r}, {30'h0, `BKT_RESP_SLV}, "unmapped read response");
    wr(`BKT_IDX_AH, 8'h12, r);
    wr(`BKT_IDX_AL, 8'h34, r);
    wr(`BKT_IDX_DH, 8'h56, r);
    wr(`BKT_IDX_DL, 8'h78, r);
    for (int i = 0; i < 24; i++) begin
      {c0, c1, a, d, fl} = TBL[i];
      wr(`BKT_IDX_CTL0, c0, r);
      wr(`BKT_IDX_CTL1, c1, r);
      pls(2);
      cyc(a, d, fl[3], fl[2]);
      pls(fl[2] ? 1 : 0);
      see(fl[1:0], "break outcome");
    end
    // a pending break and a tagged head word show in status
    wr(`BKT_IDX_CTL0, 8'h81, r);
    wr(`BKT_IDX_CTL1, 8'h40, r);
    cyc(16'h1234, 16'h5678, 1'h1, 1'h0);
    rdr(`BKT_IDX_STAT, v, r);
    chk(v, 32'h1 << `BKT_ST_PEND, "break pending in status");
    pls(0);
    see(2'h2, "pending break taken");
    wr(`BKT_IDX_CTL0, 8'hA0, r);
    cyc(16'h1234, 16'h5678, 1'h1, 1'h1);
    rdr(`BKT_IDX_STAT, v, r);
    chk(v, 32'h1 << `BKT_ST_HEAD, "tagged word at head");
    pls(1);
    see(2'h2, "tagged word popped");
    wr(`BKT_IDX_CTL0, 8'h00, r);
    strobe <= 1'h1;
    repeat (2) @(posedge clock);
    chk({31'h0, so_out}, 32'h1, "core strobe on shared pin");
    chk({31'h0, dso}, 32'h0, "debug pin never driven");
    chk({31'h0, so_oe}, 32'h1, "strobe pin driven before tagging");
    pls(3);
    @(posedge clock);
    chk({31'h0, so_oe}, 32'h0, "strobe pin released");
    chk({31'h0, scmd}, 32'h0, "serial commands blocked");
    rdr(`BKT_IDX_STAT, v, r);
    chk(v, 32'h1 << `BKT_ST_TAGACT, "tagging active");
    pod_on <= 1'h1;
    for (int c = 3; c >= 0; c--) begin
      pod_lvl <= c[1:0];
      pls(2);
      pls(4);
      cyc(16'h0000, 16'h0000, 1'h1, 1'h1);
      pls(1);
      see({c != 3, 1'h0}, "tagged head");
    end
    chk({31'h0, scmd}, 32'h0, "serial commands still blocked");
    pod_on <= 1'h0;
    dbg <= 1'h1;
    repeat (2) @(posedge clock);
    chk({31'h0, scmd}, 32'h1, "tagging ends in debug");
    dbg <= 1'h0;
    @(posedge clock);
    chk({31'h0, so_oe}, 32'h1, "strobe pin back to core");
    close_out;
  end
endmodule
`default_nettype wire
